// *** inc/oscdiv_params.svh ***
// constants for the divided oscillator output control block
// assumes a 40 MHz pclk and a master oscillator period of two pclk cycles
`ifndef OSCDIV_PARAMS_SVH
`define OSCDIV_PARAMS_SVH

// timing, in ns and in master periods
`define OSC_CLK_PERIOD_NS     25
`define OSC_MASTER_PERIOD_NS  50
`define OSC_MASTER_CLKS       (`OSC_MASTER_PERIOD_NS / `OSC_CLK_PERIOD_NS)
`define OSC_STARTUP_MASTER    500
`define OSC_STARTUP_CLKS      (`OSC_STARTUP_MASTER * `OSC_MASTER_CLKS)
`define OSC_LAT_MULT          16
`define OSC_LAT_BIAS          6

// register byte offsets
`define OSC_REG_CTRL          12'h000
`define OSC_REG_STATUS        12'h004
`define OSC_REG_CHANGES       12'h008
`define OSC_REG_STARTUP       12'h00c

// control fields
`define OSC_CTRL_SWEN_BIT     0
`define OSC_CTRL_CODE_LSB     4
`define OSC_CTRL_RESET        8'h00

// status fields
`define OSC_STAT_CODE_LSB     0
`define OSC_STAT_FLOAT_BIT    4
`define OSC_STAT_RUN_BIT      5
`define OSC_STAT_ACTIVE_BIT   6
`define OSC_STAT_LEVEL_BIT    7
`define OSC_STAT_RATIO_LSB    8

`endif

// *** inc/oscdiv_pkg.sv ***
// types and helper functions for the divided oscillator output control block
// assumes oscdiv_params.svh is on the include path
package oscdiv_pkg;
`include "oscdiv_params.svh"

    typedef enum logic [1:0] {
        ST_START  = 2'b00,
        ST_SETTLE = 2'b01,
        ST_RUN    = 2'b11
    } run_state_t;

    typedef logic [3:0] div_code_t;
    typedef logic [7:0] ratio_t;
    typedef logic [10:0] lat_t;

    // codes 0..7 give 2^code, codes 8..15 give 2^(15-code)
    function automatic ratio_t ratio_of(input div_code_t code);
        logic [2:0] e;
        e = code[3] ? ~code[2:0] : code[2:0];
        ratio_of = 8'h01 << e;
    endfunction

    function automatic logic float_of(input div_code_t code);
        float_of = code[3];
    endfunction

    // low time before the first rising edge, in pclk cycles
    function automatic ratio_t first_low_len(input ratio_t r);
        first_low_len = (r < 8'h04) ? r : 8'(`OSC_MASTER_CLKS);
    endfunction

    function automatic div_code_t code_diff(input div_code_t a, input div_code_t b);
        code_diff = (a > b) ? div_code_t'(a - b) : div_code_t'(b - a);
    endfunction

    // settling wait in pclk cycles, minus one
    function automatic lat_t latency_clks(input div_code_t diff);
        latency_clks = lat_t'(11'(`OSC_LAT_MULT) * (11'(diff) + 11'(`OSC_LAT_BIAS))
                       * 11'(`OSC_MASTER_CLKS) - 11'h001);
    endfunction
endpackage

// *** inc/code_filter_if.sv ***
// carrier between the code settling filter and the output controller
// assumes both ends share pclk
`timescale 1ns/1ps
interface code_filter_if;
    logic [3:0] code;
    logic       valid;
    logic       changed;
    modport filter (output code, output valid, output changed);
    modport user   (input code, input valid, input changed);
endinterface

// *** hw/code_settle_filter.sv ***
// settling filter for the sensed divider select code
// assumes the sample input is synchronous to clk
`timescale 1ns/1ps
module code_settle_filter (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // raw sensed code
    input  wire logic [3:0]       sample,
    // accepted code
    code_filter_if.filter         res
);
    import oscdiv_pkg::*;

    div_code_t cand_ff;
    lat_t      cnt_ff;
    div_code_t code_ff;
    logic      valid_ff;
    logic      changed_ff;
    lat_t      target;
    logic      accept;

    assign res.code    = code_ff;
    assign res.valid   = valid_ff;
    assign res.changed = changed_ff;

    ////////////////////////////////////////////////////////////////////////////
    // wait grows with the size of the step
    assign target = latency_clks(valid_ff ? code_diff(cand_ff, code_ff) : 4'h0);
    assign accept = (sample == cand_ff) && (cnt_ff >= target)
                    && (!valid_ff || (cand_ff != code_ff));

    // any mismatch restarts the stability count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cand_ff <= 4'h0;
            cnt_ff  <= 11'h000;
        end else if (sample != cand_ff) begin
            cand_ff <= sample;
            cnt_ff  <= 11'h000;
        end else if (cnt_ff < target) begin
            cnt_ff  <= cnt_ff + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // only a stable candidate is applied, never a passing value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_ff    <= 4'h0;
            valid_ff   <= 1'b0;
            changed_ff <= 1'b0;
        end else begin
            changed_ff <= accept && valid_ff;
            if (accept) begin
                code_ff  <= cand_ff;
                valid_ff <= 1'b1;
            end
        end
    end
endmodule // code_settle_filter

// *** hw/osc_out_ctrl.sv ***
// output control around a divided master oscillator, with an APB register file
// assumes out_enable_in and ratio_code_in are synchronous to pclk; one master
// period is two pclk cycles; the pad combines clk_out_o with clk_out_oe
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "oscdiv_params.svh"
module osc_out_ctrl #(
    parameter int STARTUP_CLKS = `OSC_STARTUP_CLKS
) (
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // apb slave
    input  wire logic [11:0]             paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // pins
    input  wire logic                    out_enable_in,
    input  wire oscdiv_pkg::div_code_t   ratio_code_in,
    output logic                         clk_out_o,
    output logic                         clk_out_oe
);
    import oscdiv_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    code_filter_if fres ();

    run_state_t  state_ff;
    run_state_t  nxt_state;
    logic [10:0] start_cnt_ff;
    logic        en_prev_ff;
    logic        arm;

    ratio_t      ratio_ff;
    ratio_t      cnt_ff;
    logic        phase_ff;
    ratio_t      nxt_ratio;
    ratio_t      nxt_cnt;
    logic        nxt_phase;
    ratio_t      new_ratio;
    logic        float_now;

    logic        nxt_oe;
    logic        nxt_level;
    logic        out_ff;
    logic        oe_ff;

    logic [7:0]  ctrl_ff;
    logic [15:0] changes_ff;
    logic [15:0] startup_len_ff;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic        access;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    div_code_t   code_sample;

    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = pslverr_ff;
    assign clk_out_o  = out_ff;
    assign clk_out_oe = oe_ff;

    ////////////////////////////////////////////////////////////////////////////
    // code source: sensed pin or software override
    assign code_sample = ctrl_ff[`OSC_CTRL_SWEN_BIT]
                         ? ctrl_ff[`OSC_CTRL_CODE_LSB +: 4] : ratio_code_in;

    code_settle_filter u_filter (
        .clk    (pclk),
        .rst_n  (presetn),
        .sample (code_sample),
        .res    (fres.filter)
    );

    // one code gives both settings
    assign new_ratio = ratio_of(fres.code);
    assign float_now = float_of(fres.code);

    ////////////////////////////////////////////////////////////////////////////
    // start-up sequencing
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_START: begin
                if (start_cnt_ff == 11'(STARTUP_CLKS - 1)) begin
                    nxt_state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (fres.valid) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                nxt_state = ST_RUN;
            end
            default: begin
                nxt_state = ST_START;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_START;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_cnt_ff <= 11'h000;
        end else if (state_ff == ST_START) begin
            start_cnt_ff <= start_cnt_ff + 11'h001;
        end
    end

    // cycles spent before running, shows any extension
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            startup_len_ff <= 16'h0000;
        end else if (state_ff != ST_RUN && startup_len_ff != 16'hffff) begin
            startup_len_ff <= startup_len_ff + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // enable rise detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_prev_ff <= 1'b0;
        end else begin
            en_prev_ff <= out_enable_in;
        end
    end

    // re-phase the divider on enable rise or at start-up end
    assign arm = ((state_ff == ST_SETTLE) && fres.valid && out_enable_in)
                 || ((state_ff == ST_RUN) && out_enable_in && !en_prev_ff);

    ////////////////////////////////////////////////////////////////////////////
    // divider: half period of ratio pclk cycles
    always_comb begin
        nxt_ratio = ratio_ff;
        nxt_cnt   = cnt_ff;
        nxt_phase = phase_ff;
        if (arm) begin
            nxt_ratio = new_ratio;
            nxt_phase = 1'b0;
            nxt_cnt   = first_low_len(new_ratio) - 8'h01;
        end else if (cnt_ff == 8'h00) begin
            nxt_phase = ~phase_ff;
            if (!phase_ff) begin
                nxt_ratio = new_ratio;
                nxt_cnt   = new_ratio - 8'h01;
            end else begin
                nxt_cnt   = ratio_ff - 8'h01;
            end
        end else begin
            nxt_cnt = cnt_ff - 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ratio_ff <= 8'h01;
            cnt_ff   <= 8'h00;
            phase_ff <= 1'b0;
        end else begin
            ratio_ff <= nxt_ratio;
            cnt_ff   <= nxt_cnt;
            phase_ff <= nxt_phase;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pad control
    always_comb begin
        nxt_oe    = 1'b0;
        nxt_level = 1'b0;
        if (nxt_state == ST_RUN) begin
            if (out_enable_in) begin
                nxt_oe    = 1'b1;
                nxt_level = nxt_phase;
            end else begin
                nxt_oe    = !float_now;
                nxt_level = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ff <= 1'b0;
            oe_ff  <= 1'b0;
        end else begin
            out_ff <= nxt_level;
            oe_ff  <= nxt_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // accepted code changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            changes_ff <= 16'h0000;
        end else if (fres.changed && changes_ff != 16'hffff) begin
            changes_ff <= changes_ff + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, write lands on the completing edge
    assign access = psel && penable;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (paddr)
            `OSC_REG_CTRL: begin
                rd_word[7:0] = ctrl_ff;
            end
            `OSC_REG_STATUS: begin
                rd_word[`OSC_STAT_CODE_LSB +: 4]  = fres.code;
                rd_word[`OSC_STAT_FLOAT_BIT]      = float_now;
                rd_word[`OSC_STAT_RUN_BIT]        = (state_ff == ST_RUN);
                rd_word[`OSC_STAT_ACTIVE_BIT]     = oe_ff;
                rd_word[`OSC_STAT_LEVEL_BIT]      = out_ff;
                rd_word[`OSC_STAT_RATIO_LSB +: 8] = ratio_ff;
            end
            `OSC_REG_CHANGES: begin
                rd_word[15:0] = changes_ff;
            end
            `OSC_REG_STARTUP: begin
                rd_word[15:0] = startup_len_ff;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else if (access && !pready_ff) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= !rd_hit;
            prdata_ff  <= pwrite ? 32'h0000_0000 : rd_word;
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `OSC_CTRL_RESET;
        end else if (access && pready_ff && pwrite && paddr == `OSC_REG_CTRL) begin
            ctrl_ff <= pwdata[7:0];
        end
    end
endmodule // osc_out_ctrl

// *** bench/osc_out_ctrl_sva.sv ***
// checker for the divided oscillator output control block
// assumes only the top ports are visible; one pclk domain
`timescale 1ns/1ps
module osc_out_ctrl_sva #(
    parameter int STARTUP_CLKS = 1000
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // pins
    input wire logic out_enable_in,
    input wire logic clk_out_o,
    input wire logic clk_out_oe
);
    localparam int SETTLE_CLKS = 16 * 6 * 2;
    logic [10:0] up_ff;
    logic [7:0]  hi_ff;

    ////////////////////////////////////////////////////////////////
    // cycles since release, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) up_ff <= 11'h000;
        else if (up_ff != 11'h7ff) up_ff <= up_ff + 11'h001;
    end

    // length of the current high run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hi_ff <= 8'h00;
        else hi_ff <= clk_out_o ? hi_ff + 8'h01 : 8'h00;
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_startup_float: assert property (
        up_ff < STARTUP_CLKS |-> !clk_out_oe) else $error("output driven during start-up");
    a_code_settle: assert property (
        up_ff < SETTLE_CLKS |-> !clk_out_oe) else $error("output driven before a code settled");
    a_enable_drives: assert property (
        out_enable_in && clk_out_oe |=> clk_out_oe) else $error("enabled output released");
    a_disable_low: assert property (
        !out_enable_in |=> !clk_out_o) else $error("output high after enable fell");
    a_rise_low_first: assert property (
        $rose(out_enable_in) |=> !clk_out_o) else $error("no low before first pulse");
    a_enable_delay: assert property (
        $rose(out_enable_in) ##1 (clk_out_oe && out_enable_in) ##1 out_enable_in [*2]
        |-> clk_out_o || $past(clk_out_o)) else $error("enable delay too long");
    a_pulse_width: assert property (
        $fell(clk_out_o) && $past(out_enable_in) |-> $onehot(hi_ff)) else $error("malformed high pulse");
    a_width_limit: assert property (
        clk_out_o |-> hi_ff < 8'h80) else $error("high pulse longer than largest ratio");
    a_apb_answer: assert property (
        psel && penable && !pready |=> pready ##1 !pready) else $error("apb answer out of place");
endmodule // osc_out_ctrl_sva

bind osc_out_ctrl osc_out_ctrl_sva #(.STARTUP_CLKS(STARTUP_CLKS)) u_osc_out_ctrl_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .out_enable_in(out_enable_in), .clk_out_o(clk_out_o), .clk_out_oe(clk_out_oe));

// *** bench/ratio_pin_model.sv ***
// model of the enable driver and the divider on the ratio pin
// assumes the bench sets the wanted code and enable level after a pclk edge
`timescale 1ns/1ps
module ratio_pin_model (
    // clock
    input  wire logic                  pclk,
    // bench requests
    input  wire oscdiv_pkg::div_code_t set_code,
    input  wire logic                  set_en,
    // device pins
    output oscdiv_pkg::div_code_t      ratio_code,
    output logic                       out_enable,
    input  wire logic                  clk_out_o,
    input  wire logic                  clk_out_oe,
    output logic                       pad
);
    import oscdiv_pkg::*;

    // sensed band of the divider, one conversion per clock
    always @(posedge pclk) ratio_code <= set_code;
    assign out_enable = set_en;
    // no pull on the line: floats when not driven
    assign pad = clk_out_oe ? clk_out_o : 1'bz;
endmodule // ratio_pin_model

// *** bench/testbench.sv ***
// self-checking bench for the divided oscillator output control block
// assumes the package and interface compile first
`timescale 1ns/1ps
module testbench;
    import oscdiv_pkg::*;
    localparam logic [11:0] A_CTRL = 12'h000, A_STAT = 12'h004, A_CHG = 12'h008, A_STUP = 12'h00c;
    logic        pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        set_en, out_enable_in, clk_out_o, clk_out_oe, pad, serr;
    div_code_t   set_code, ratio_code_in;
    int          n_mismatch = 0, check_count = 0, span;

    always #12.5 pclk = ~pclk;

    osc_out_ctrl #(.STARTUP_CLKS(20)) u_osc_out_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .out_enable_in(out_enable_in), .ratio_code_in(ratio_code_in),
        .clk_out_o(clk_out_o), .clk_out_oe(clk_out_oe));
    ratio_pin_model u_ratio_pin_model (.pclk(pclk), .set_code(set_code), .set_en(set_en),
        .ratio_code(ratio_code_in), .out_enable(out_enable_in), .clk_out_o(clk_out_o),
        .clk_out_oe(clk_out_oe), .pad(pad));

    ////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // status with the output disabled and the block running
    function automatic logic [31:0] status_exp(input int c);
        logic fl;
        fl = (c >= 8);
        return {16'h0000, 8'(fl ? 1 << (15 - c) : 1 << c), 1'b0, ~fl, 1'b1, fl, 4'(c)};
    endfunction

    task run_pulse(input int r, input logic fl);
        int d, h, l;
        d = 0;
        h = 0;
        l = 0;
        @(posedge pclk);
        set_en <= 1'b1;
        @(posedge pclk);
        while (clk_out_o !== 1'b1 && d < 300) begin
            @(posedge pclk);
            d++;
        end
        check(d, (r < 4 ? r : 2) + 1);
        check(clk_out_oe, 1'b1);
        while (clk_out_o === 1'b1 && h < 300) begin
            @(posedge pclk);
            h++;
        end
        while (clk_out_o === 1'b0 && l < 300) begin
            @(posedge pclk);
            l++;
        end
        check({h[15:0], l[15:0]}, {r[15:0], r[15:0]});
        set_en <= 1'b0;
        repeat (2) @(posedge pclk);
        check(clk_out_o, 1'b0);
        check(clk_out_oe, !fl);
        check(pad, fl ? 1'bz : 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        set_en = 1'b0;
        set_code = 4'h2;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (100) @(posedge pclk);
        check(clk_out_oe, 1'b0);
        repeat (300) @(posedge pclk);
        check({clk_out_oe, clk_out_o}, 2'b10);
        apb(A_STAT, 1'b0, 32'h0);
        check(rd, status_exp(2));
        apb(A_STUP, 1'b0, 32'h0);
        check(rd > 32'd191 && rd < 32'd200, 1'b1);
        apb(12'h010, 1'b0, 32'h0);
        check(serr, 1'b1);
        check(rd, 32'h0);
        apb(A_CTRL, 1'b1, 32'hffff_ff21);
        apb(A_CTRL, 1'b0, 32'h0);
        check(rd, 32'h0000_0021);
        apb(A_CTRL, 1'b1, 32'h0);
        for (int c = 0; c < 16; c++) begin
            set_code <= 4'(c);
            repeat (700) @(posedge pclk);
            apb(A_STAT, 1'b0, 32'h0);
            check(rd, status_exp(c));
            run_pulse(c >= 8 ? 1 << (15 - c) : 1 << c, c >= 8);
        end
        set_code <= 4'hd;
        repeat (225) @(posedge pclk);
        apb(A_STAT, 1'b0, 32'h0);
        check(rd[3:0], 4'hf);
        repeat (60) @(posedge pclk);
        apb(A_STAT, 1'b0, 32'h0);
        check(rd[3:0], 4'hd);
        set_code <= 4'h9;
        repeat (200) @(posedge pclk);
        set_code <= 4'hd;
        repeat (400) @(posedge pclk);
        apb(A_CHG, 1'b0, 32'h0);
        check(rd, 32'h0000_0011);
        presetn <= 1'b0;
        set_en <= 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (50) @(posedge pclk);
        check(clk_out_oe, 1'b0);
        // enabled at start-up end: one master period low, then high
        span = 0;
        while (clk_out_oe !== 1'b1 && span < 400) begin
            @(posedge pclk);
            span++;
        end
        check({clk_out_oe, clk_out_o}, 2'b10);
        span = 0;
        while (clk_out_o !== 1'b1 && span < 20) begin
            @(posedge pclk);
            span++;
        end
        check(span, 2);
        conclude();
    end

    initial begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        conclude();
    end
endmodule // testbench
